// File: core/adc_conversion_sequencer.sv
// Functional notes
// - four-input part routes channels by a 3-bit select; single-ended grounds negative input
// - modulator tick is the 1 MHz oscillator divided by four
// - gain field picks one of six ranges, wide to narrow
// - one code step equals range over two to the eleventh
// - part without gain stage always uses the 2.048 V range
// - rate field selects one of seven output data rates
// - conversion time is one period of the selected data rate
// - power-up loads config defaults and powers down, logic stays live
// - general-call reset byte acts like power-up reset, except the clock divider keeps counting and the input synchronisers and settings snapshot keep their values
// - mode bit 1 means powered-down single-shot, also the default
// - single-shot stays powered down until start bit written one
// - start wakes in about 25 us, clears start bit, runs one conversion
// - single-shot result ready sets start bit and powers down
// - start written during a conversion is ignored
// - mode bit 0 converts back to back, storing each result
// - new config takes effect only after the running conversion
// - writing mode 1 or reset leaves continuous; mode 0 enters it
// - result register holds the latest finished conversion until a reset clears it to zero
// - general-call address with write direction is acknowledged, next byte checked
`timescale 1ns/1ns
`include "adc_seq_map.svh"
module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter bit HAS_MUX = 1'b1,
   parameter bit HAS_GAIN = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // general call from the serial front end
   input wire logic gc_addr_valid,
   input wire logic [6:0] gc_addr,
   input wire logic gc_rw,
   input wire logic gc_byte_valid,
   input wire logic [7:0] gc_byte,
   output logic gc_ack,
   // analog samples in 0.125 mV units
   input wire logic signed [15:0] analog_input_0,
   input wire logic signed [15:0] analog_input_1,
   input wire logic signed [15:0] analog_input_2,
   input wire logic signed [15:0] analog_input_3,
   // status
   output logic converter_powered,
   output logic conversion_done
);
   localparam int WAKE_CYCLES = `WAKE_TIME_US * (`CLK_HZ / 1000000);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   seq_state_e state_reg;
   logic start_status_bit_reg;
   conv_cfg_s cfg_reg;
   conv_cfg_s snap_reg;
   logic [15:0] result_reg;
   logic [11:0] wake_cnt_reg;
   logic [10:0] conv_cnt_reg;
   logic [10:0] period;
   logic gc_armed_reg;
   logic soft_rst;
   logic osc_tick;
   logic mod_tick;
   logic cfg_wr;
   logic start_req;
   logic conv_end;
   logic signed [15:0] ain_meta[4];
   logic signed [15:0] ain_sync[4];
   logic signed [15:0] ain_raw[4];
   conv_if cv ();

   mod_clock_divider u_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .osc_tick(osc_tick),
      .mod_tick(mod_tick)
   );

   code_scaler #(.HAS_GAIN(HAS_GAIN)) u_scale (
      .clk(clk),
      .sys_rst(sys_rst),
      .cv(cv.scale)
   );

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   assign ain_raw[0] = analog_input_0;
   assign ain_raw[1] = analog_input_1;
   assign ain_raw[2] = analog_input_2;
   assign ain_raw[3] = analog_input_3;

   // front-end samples come from another timing domain
   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            ain_meta[i] <= 16'sh0000;
            ain_sync[i] <= 16'sh0000;
         end else begin
            ain_meta[i] <= ain_raw[i];
            ain_sync[i] <= ain_meta[i];
         end
      end
   end

   // ------------------------------------------------------------
   // input routing
   // ------------------------------------------------------------
   always_comb begin
      cv.positive_converter_input = ain_sync[0];
      cv.negative_converter_input = ain_sync[1];
      if (HAS_MUX) begin
         unique case (snap_reg.input_select_field)
            3'h0: begin
               cv.positive_converter_input = ain_sync[0];
               cv.negative_converter_input = ain_sync[1];
            end
            3'h1: begin
               cv.positive_converter_input = ain_sync[0];
               cv.negative_converter_input = ain_sync[3];
            end
            3'h2: begin
               cv.positive_converter_input = ain_sync[1];
               cv.negative_converter_input = ain_sync[3];
            end
            3'h3: begin
               cv.positive_converter_input = ain_sync[2];
               cv.negative_converter_input = ain_sync[3];
            end
            default: begin
               cv.positive_converter_input = ain_sync[snap_reg.input_select_field[1:0]];
               cv.negative_converter_input = 16'sh0000;
            end
         endcase
      end
   end

   assign cv.gain_range_field = snap_reg.gain_range_field;

   // ------------------------------------------------------------
   // general call
   // ------------------------------------------------------------
   // only the all-zero address with a write direction is taken here
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gc_armed_reg <= 1'b0;
         gc_ack <= 1'b0;
      end else begin
         gc_ack <= gc_addr_valid && (gc_addr == `GC_ADDR) && !gc_rw;
         if (gc_addr_valid) begin
            gc_armed_reg <= (gc_addr == `GC_ADDR) && !gc_rw;
         end else if (gc_byte_valid) begin
            gc_armed_reg <= 1'b0;
         end
      end
   end

   assign soft_rst = gc_armed_reg && gc_byte_valid && (gc_byte == `GC_RESET_CMD);

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------
   assign cfg_wr = reg_wr && (reg_addr == `REG_CONFIG);
   // a start is only honoured while powered down
   assign start_req = cfg_wr && reg_wdata[`CFG_START_BIT] && (state_reg == ST_PWRDN);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_reg <= conv_cfg_s'(10'(`CFG_RESET >> `CFG_RATE_LSB));
      end else if (soft_rst) begin
         cfg_reg <= conv_cfg_s'(10'(`CFG_RESET >> `CFG_RATE_LSB));
      end else if (cfg_wr) begin
         cfg_reg <= conv_cfg_s'(10'((reg_wdata & `CFG_WMASK) >> `CFG_RATE_LSB));
      end
   end

   // hardware completion wins over any software write in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         start_status_bit_reg <= 1'(`CFG_RESET >> `CFG_START_BIT);
      end else if (soft_rst) begin
         start_status_bit_reg <= 1'(`CFG_RESET >> `CFG_START_BIT);
      end else if (conv_end && snap_reg.mode) begin
         start_status_bit_reg <= 1'b1;
      end else if (start_req) begin
         start_status_bit_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // conversion period
   // ------------------------------------------------------------
   always_comb begin
      unique case (snap_reg.rate_select_field)
         3'h0: period = 11'd`RATE_CNT_128;
         3'h1: period = 11'd`RATE_CNT_250;
         3'h2: period = 11'd`RATE_CNT_490;
         3'h3: period = 11'd`RATE_CNT_920;
         3'h4: period = 11'd`RATE_CNT_1600;
         3'h5: period = 11'd`RATE_CNT_2400;
         default: period = 11'd`RATE_CNT_3300;
      endcase
   end

   assign conv_end = (state_reg == ST_CONVERT) && mod_tick && (conv_cnt_reg == period - 11'd1);

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_PWRDN;
      end else if (soft_rst) begin
         state_reg <= ST_PWRDN;
      end else begin
         unique case (state_reg)
            ST_PWRDN: begin
               if (start_req || !cfg_reg.mode) begin
                  state_reg <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (wake_cnt_reg == 12'(WAKE_CYCLES - 1)) begin
                  state_reg <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (conv_end && cfg_reg.mode) begin
                  state_reg <= ST_PWRDN;
               end
            end
            default: state_reg <= ST_PWRDN;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_cnt_reg <= 12'h000;
      end else if (state_reg == ST_WAKE && !soft_rst) begin
         wake_cnt_reg <= wake_cnt_reg + 12'h001;
      end else begin
         wake_cnt_reg <= 12'h000;
      end
   end

   // settings are frozen for a whole conversion
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         snap_reg <= conv_cfg_s'(10'(`CFG_RESET >> `CFG_RATE_LSB));
      end else if (state_reg == ST_WAKE || conv_end) begin
         snap_reg <= cfg_reg;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_cnt_reg <= 11'h000;
      end else if (state_reg != ST_CONVERT || conv_end || soft_rst) begin
         conv_cnt_reg <= 11'h000;
      end else if (mod_tick) begin
         conv_cnt_reg <= conv_cnt_reg + 11'h001;
      end
   end

   // ------------------------------------------------------------
   // result
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_reg <= 16'h0000;
         conversion_done <= 1'b0;
      end else if (soft_rst) begin
         result_reg <= 16'h0000;
         conversion_done <= 1'b0;
      end else begin
         conversion_done <= conv_end;
         if (conv_end) begin
            result_reg <= {cv.code, 4'h0};
         end
      end
   end

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `REG_RESULT: reg_rdata <= result_reg;
            `REG_CONFIG: reg_rdata <= {start_status_bit_reg, 15'(cfg_reg) << `CFG_RATE_LSB};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   assign converter_powered = (state_reg != ST_PWRDN);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_start_clears_status: assert property (@(posedge clk) disable iff (sys_rst)
      (start_req && !soft_rst) |=> !start_status_bit_reg && state_reg == ST_WAKE)
      else $error("start did not clear status or wake");
   chk_wake_to_convert: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == ST_WAKE && wake_cnt_reg == 12'(WAKE_CYCLES - 1) && !soft_rst)
      |=> state_reg == ST_CONVERT)
      else $error("wake time wrong");
   chk_busy_start_ignored: assert property (@(posedge clk) disable iff (sys_rst)
      (cfg_wr && reg_wdata[`CFG_START_BIT] && state_reg == ST_CONVERT && !conv_end && !soft_rst)
      |=> state_reg == ST_CONVERT && $stable(snap_reg) && $stable(start_status_bit_reg)
      && conv_cnt_reg == $past(conv_cnt_reg) + 11'($past(mod_tick)))
      else $error("start disturbed a running conversion");
   chk_single_done: assert property (@(posedge clk) disable iff (sys_rst)
      (conv_end && cfg_reg.mode && snap_reg.mode && !soft_rst)
      |=> start_status_bit_reg && state_reg == ST_PWRDN && conversion_done)
      else $error("single-shot end not flagged");
   chk_cont_restart: assert property (@(posedge clk) disable iff (sys_rst)
      (conv_end && !cfg_reg.mode && !soft_rst) |=> state_reg == ST_CONVERT && conv_cnt_reg == 11'h000)
      else $error("continuous conversion stopped");
   chk_result_latest: assert property (@(posedge clk) disable iff (sys_rst)
      conversion_done |-> result_reg[15:4] == $past(cv.code))
      else $error("result not the latest conversion");
   chk_settings_frozen: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == ST_CONVERT && !conv_end) |=> $stable(snap_reg))
      else $error("settings changed mid conversion");
   chk_general_reset: assert property (@(posedge clk) disable iff (sys_rst)
      soft_rst |=> state_reg == ST_PWRDN && start_status_bit_reg && result_reg == 16'h0000)
      else $error("general-call reset incomplete");
   chk_single_ended: assert property (@(posedge clk) disable iff (sys_rst)
      (HAS_MUX && snap_reg.input_select_field[2]) |-> cv.negative_converter_input == 16'sh0000)
      else $error("negative input not grounded");
endmodule : adc_conversion_sequencer

// File: core/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
// ------------------------------------------------------------
// register indices and config field layout
// ------------------------------------------------------------
`define REG_RESULT 8'h00
`define REG_CONFIG 8'h01
`define CFG_START_BIT 15
`define CFG_SEL_LSB 12
`define CFG_GAIN_LSB 9
`define CFG_MODE_BIT 8
`define CFG_RATE_LSB 5
`define CFG_RESET 16'h8580
`define CFG_WMASK 16'h7FE0
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_HZ 100000000
`define OSC_HZ 1000000
`define MOD_DIV 4
`define WAKE_TIME_US 25
`define RATE_CNT_128 1953
`define RATE_CNT_250 1000
`define RATE_CNT_490 510
`define RATE_CNT_920 271
`define RATE_CNT_1600 156
`define RATE_CNT_2400 104
`define RATE_CNT_3300 75
// ------------------------------------------------------------
// general call
// ------------------------------------------------------------
`define GC_ADDR 7'h00
`define GC_RESET_CMD 8'h06
// ------------------------------------------------------------
// code limits and step sizes in 0.125 mV units
// ------------------------------------------------------------
`define CODE_MAX 2047
`define CODE_MIN -2048
`define LSB_6V144 24
`define LSB_4V096 16
`define LSB_2V048 8
`define LSB_1V024 4
`define LSB_0V512 2
`define LSB_0V256 1
`endif

// File: core/adc_seq_pkg.sv
package adc_seq_pkg;
   typedef enum logic [1:0] {
      ST_PWRDN = 2'b00,
      ST_WAKE = 2'b01,
      ST_CONVERT = 2'b11
   } seq_state_e;
   typedef struct packed {
      logic [2:0] input_select_field;
      logic [2:0] gain_range_field;
      logic mode;
      logic [2:0] rate_select_field;
   } conv_cfg_s;
endpackage : adc_seq_pkg

// File: core/conv_if.sv
`timescale 1ns/1ns
interface conv_if;
   import adc_seq_pkg::*;
   logic signed [15:0] positive_converter_input;
   logic signed [15:0] negative_converter_input;
   logic [2:0] gain_range_field;
   logic signed [11:0] code;
   modport seq (output positive_converter_input, output negative_converter_input,
      output gain_range_field, input code);
   modport scale (input positive_converter_input, input negative_converter_input,
      input gain_range_field, output code);
endinterface : conv_if

// File: core/mod_clock_divider.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"
module mod_clock_divider (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // rate ticks
   output logic osc_tick,
   output logic mod_tick
);
   localparam int OSC_DIV = `CLK_HZ / `OSC_HZ;
   logic [6:0] osc_cnt_reg;
   logic [1:0] mod_cnt_reg;

   // 100 MHz down to the 1 MHz oscillator rate, then by four
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_cnt_reg <= 7'h00;
      end else if (osc_cnt_reg == 7'(OSC_DIV - 1)) begin
         osc_cnt_reg <= 7'h00;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mod_cnt_reg <= 2'h0;
      end else if (osc_tick) begin
         mod_cnt_reg <= mod_cnt_reg + 2'h1;
      end
   end

   assign osc_tick = (osc_cnt_reg == 7'(OSC_DIV - 1));
   assign mod_tick = osc_tick && (mod_cnt_reg == 2'(`MOD_DIV - 1));

   chk_mod_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
      mod_tick |=> !mod_tick && (osc_cnt_reg == 7'h00) && (mod_cnt_reg == 2'h0))
      else $error("modulator tick spacing wrong");
endmodule : mod_clock_divider

// File: core/code_scaler.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"
module code_scaler #(
   parameter bit HAS_GAIN = 1'b1
) (
   // clock and reset for checks only
   input wire logic clk,
   input wire logic sys_rst,
   // converter side
   conv_if.scale cv
);
   logic signed [16:0] diff;
   logic signed [16:0] quot;
   logic signed [16:0] lsb;

   // input difference divided by the step size of the range
   always_comb begin
      diff = 17'(cv.positive_converter_input) - 17'(cv.negative_converter_input);
      lsb = 17'sd`LSB_2V048;
      if (HAS_GAIN) begin
         unique case (cv.gain_range_field)
            3'h0: lsb = 17'sd`LSB_6V144;
            3'h1: lsb = 17'sd`LSB_4V096;
            3'h2: lsb = 17'sd`LSB_2V048;
            3'h3: lsb = 17'sd`LSB_1V024;
            3'h4: lsb = 17'sd`LSB_0V512;
            default: lsb = 17'sd`LSB_0V256;
         endcase
      end
      quot = diff / lsb;
   end

   // clamp to the 12-bit two's-complement span
   always_comb begin
      if (quot > 17'sd`CODE_MAX) begin
         cv.code = 12'sd`CODE_MAX;
      end else if (quot < -17'sd2048) begin
         cv.code = 12'sh800;
      end else begin
         cv.code = quot[11:0];
      end
   end

   chk_code_clamp_high: assert property (@(posedge clk) disable iff (sys_rst)
      (quot > 17'sd`CODE_MAX) |-> (cv.code == 12'sd`CODE_MAX))
      else $error("positive clamp missing");
   chk_fixed_range: assert property (@(posedge clk) disable iff (sys_rst)
      !HAS_GAIN |-> (lsb == 17'sd`LSB_2V048))
      else $error("fixed range not kept");
endmodule : code_scaler

// File: tb/host_model.sv
`timescale 1ns/1ns
module host_model (
   // clock
   input wire logic clk,
   // register port
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // general call
   output logic gc_addr_valid,
   output logic [6:0] gc_addr,
   output logic gc_rw,
   output logic gc_byte_valid,
   output logic [7:0] gc_byte,
   input wire logic gc_ack
);
   initial begin
      reg_addr = 8'hFF;
      reg_wdata = 16'hFFFF;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      gc_addr_valid = 1'b0;
      gc_addr = 7'h7F;
      gc_rw = 1'b1;
      gc_byte_valid = 1'b0;
      gc_byte = 8'hFF;
   end
   // once a strobe drops, address and data flip so stale values never look valid
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk);
      reg_wr <= wr;
      reg_rd <= ~wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
      q = reg_rdata;
   endtask : xfer
   // address byte first, command byte two cycles later
   task automatic gen_call(input logic [6:0] a, input logic rw, input logic [7:0] cmd, output logic ack);
      @(posedge clk);
      gc_addr_valid <= 1'b1;
      gc_addr <= a;
      gc_rw <= rw;
      @(posedge clk);
      gc_addr_valid <= 1'b0;
      gc_addr <= ~a;
      gc_rw <= ~rw;
      #1;
      ack = gc_ack;
      @(posedge clk);
      gc_byte_valid <= 1'b1;
      gc_byte <= cmd;
      @(posedge clk);
      gc_byte_valid <= 1'b0;
      gc_byte <= ~cmd;
   endtask : gen_call
endmodule : host_model

// File: tb/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ns
module adc_conversion_sequencer_tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic gc_addr_valid;
   logic [6:0] gc_addr;
   logic gc_rw;
   logic gc_byte_valid;
   logic [7:0] gc_byte;
   logic gc_ack;
   logic converter_powered;
   logic conversion_done;
   logic signed [15:0] ain [4];
   int num_errors = 0;
   int checked = 0;
   always #5 clk = ~clk;
   host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gc_addr_valid(gc_addr_valid), .gc_addr(gc_addr),
      .gc_rw(gc_rw), .gc_byte_valid(gc_byte_valid), .gc_byte(gc_byte), .gc_ack(gc_ack));
   adc_conversion_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .gc_addr_valid(gc_addr_valid), .gc_addr(gc_addr), .gc_rw(gc_rw), .gc_byte_valid(gc_byte_valid),
      .gc_byte(gc_byte), .gc_ack(gc_ack), .analog_input_0(ain[0]), .analog_input_1(ain[1]),
      .analog_input_2(ain[2]), .analog_input_3(ain[3]), .converter_powered(converter_powered),
      .conversion_done(conversion_done));
   // ------------------------------------------------------------
   // checking and reference model
   // ------------------------------------------------------------
   task automatic close_out();
      $display("errors %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check16
   task automatic check_span(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : check_span
   function automatic logic [15:0] cfg(logic st, logic [2:0] sel, logic [2:0] gn, logic md, logic [2:0] rt);
      return {st, sel, gn, md, rt, 5'h00};
   endfunction : cfg
   // truncation toward zero, then clamp to the 12-bit code range
   function automatic logic [15:0] model_result(logic [2:0] sel, logic [2:0] gn);
      int lsb_tab [8] = '{24, 16, 8, 4, 2, 1, 1, 1};
      int diff;
      int code;
      case (sel)
         3'h0: diff = ain[0] - ain[1];
         3'h1: diff = ain[0] - ain[3];
         3'h2: diff = ain[1] - ain[3];
         3'h3: diff = ain[2] - ain[3];
         default: diff = ain[sel[1:0]];
      endcase
      code = diff / lsb_tab[gn];
      if (code > 2047) code = 2047;
      if (code < -2048) code = -2048;
      return {code[11:0], 4'h0};
   endfunction : model_result
   task automatic wait_done(input int limit, output int cyc);
      cyc = 0;
      do begin
         @(posedge clk);
         #1;
         cyc++;
      end while (conversion_done !== 1'b1 && cyc < limit);
      if (conversion_done !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
         close_out();
      end
   endtask : wait_done
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [15:0] rd;
      logic ack;
      logic [2:0] sel;
      logic [2:0] gn;
      int cyc;
      int quiet;
      time t0;
      for (int i = 0; i < 4; i++) ain[i] = 16'h0000;
      void'($urandom(87));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      u_host.xfer(1'b0, 8'h01, 16'h0000, rd);
      check16(rd, 16'h8580);
      u_host.xfer(1'b0, 8'h00, 16'h0000, rd);
      check16(rd, 16'h0000);
      u_host.xfer(1'b0, 8'h05, 16'h0000, rd);
      check16(rd, 16'h0000);
      check16({15'h0000, converter_powered}, 16'h0000);
      // single shot with random range and channel
      sel = 3'($urandom_range(7));
      gn = 3'($urandom_range(7));
      @(posedge clk);
      for (int i = 0; i < 4; i++) ain[i] <= 16'($urandom);
      u_host.xfer(1'b1, 8'h01, cfg(1'b1, sel, gn, 1'b1, 3'h7), rd);
      t0 = $time - 1;
      check16({15'h0000, converter_powered}, 16'h0001);
      u_host.xfer(1'b0, 8'h01, 16'h0000, rd);
      check16(rd, cfg(1'b0, sel, gn, 1'b1, 3'h7));
      repeat (3000) @(posedge clk);
      u_host.xfer(1'b1, 8'h01, cfg(1'b1, sel, gn, 1'b1, 3'h7), rd);
      wait_done(34000, cyc);
      check_span(int'(($time - t0) / 10), 2500 + 74 * 400, 2500 + 75 * 400);
      check16({15'h0000, converter_powered}, 16'h0000);
      u_host.xfer(1'b0, 8'h01, 16'h0000, rd);
      check16(rd, cfg(1'b1, sel, gn, 1'b1, 3'h7));
      u_host.xfer(1'b0, 8'h00, 16'h0000, rd);
      check16(rd, model_result(sel, gn));
      quiet = 0;
      repeat (600) begin
         @(posedge clk);
         #1;
         if (conversion_done !== 1'b0 || converter_powered !== 1'b0) quiet++;
      end
      check_span(quiet, 0, 0);
      // continuous, settings changed inside the first conversion
      u_host.xfer(1'b1, 8'h01, cfg(1'b0, 3'h4, 3'h0, 1'b0, 3'h7), rd);
      repeat (3000) @(posedge clk);
      u_host.xfer(1'b1, 8'h01, cfg(1'b0, 3'h5, 3'h5, 1'b0, 3'h7), rd);
      wait_done(34000, cyc);
      u_host.xfer(1'b0, 8'h00, 16'h0000, rd);
      check16(rd, model_result(3'h4, 3'h0));
      wait_done(31000, cyc);
      check_span(cyc + 2, 30000, 30000);
      check16({15'h0000, converter_powered}, 16'h0001);
      u_host.xfer(1'b0, 8'h00, 16'h0000, rd);
      check16(rd, model_result(3'h5, 3'h5));
      // general call: read direction is ignored, write direction resets
      u_host.gen_call(7'h00, 1'b1, 8'h06, ack);
      check16({15'h0000, ack}, 16'h0000);
      #1;
      check16({15'h0000, converter_powered}, 16'h0001);
      u_host.gen_call(7'h00, 1'b0, 8'h06, ack);
      check16({15'h0000, ack}, 16'h0001);
      #1;
      check16({15'h0000, converter_powered}, 16'h0000);
      u_host.xfer(1'b0, 8'h01, 16'h0000, rd);
      check16(rd, 16'h8580);
      u_host.xfer(1'b0, 8'h00, 16'h0000, rd);
      check16(rd, 16'h0000);
      close_out();
   end
endmodule : adc_conversion_sequencer_tb_top
